// ### hw/brake_pwm.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Brake output stage with a phase accumulator PWM.
module brake_pwm (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic brakeOpen,
  input wire logic [31:0] freqHz,
  input wire logic [31:0] dutyPct,
  output logic brakeOut
);

  logic [31:0] phase_q;
  logic [31:0] phase_d;
  logic out_q;
  logic out_d;
  logic [31:0] threshold;

  // The accumulator adds the frequency each cycle and wraps at the clock rate,
  // so one wrap is one PWM period without a divider.
  always_comb begin
    threshold = 32'(dutyPct * brake_pkg::CYCLES_PER_PERCENT);
    if (phase_q + freqHz >= brake_pkg::CLOCK_HZ_W) begin
      phase_d = phase_q + freqHz - brake_pkg::CLOCK_HZ_W;
    end else begin
      phase_d = phase_q + freqHz;
    end
    if (!brakeOpen) begin
      out_d = 1'b0;
    end else if (dutyPct == '0 || freqHz == '0) begin
      out_d = 1'b1;
    end else begin
      out_d = (phase_q < threshold);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      out_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      out_q <= out_d;
    end
  end

  assign brakeOut = out_q;

endmodule // brake_pwm

// ### hw/brake_sequencer.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Brake sequencing, standstill current reduction and current readout, with
// object dictionary access by index and subindex.
module brake_sequencer #(
  parameter int CYCLES_PER_MS = brake_pkg::CYCLES_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic odWrite,
  input wire logic odRead,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubindex,
  input wire logic [31:0] odWriteData,
  output logic [31:0] odReadData,
  output logic odAck,
  output logic odError,
  input wire logic enableRequest,
  input wire logic motorStandstill,
  input wire logic closedLoopActive,
  input wire logic [31:0] ratedCurrentMa,
  input wire logic signed [31:0] measDirect,
  input wire logic signed [31:0] measQuadrature,
  input wire logic signed [31:0] measAlpha,
  input wire logic signed [31:0] measBeta,
  input wire logic signed [31:0] measActual,
  output logic motorCurrentOn,
  output logic brakeOpenCmd,
  output logic brakeOut,
  output logic operationEnabled,
  output logic reductionActive,
  output logic [31:0] currentSetpointMa
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Standstill current from the reduction setting.
  function automatic logic [31:0] reducedCurrent(input logic signed [31:0] setting,
                                                 input logic [31:0] rated);
    logic [63:0] prod;
    logic [63:0] quot;
    prod = '0;
    quot = '0;
    if (setting >= 0 && $unsigned(setting) < rated) begin
      reducedCurrent = $unsigned(setting);
    end else if (setting < 0 && setting >= brake_pkg::PERCENT_MIN) begin
      // A setting of -100 gives a zero factor and so zero current.
      prod = {32'h0, rated} * 64'($unsigned(setting + brake_pkg::PERCENT_FULL));
      quot = prod / 64'(brake_pkg::PERCENT_FULL);
      reducedCurrent = quot[31:0];
    end else begin
      reducedCurrent = rated; // Out-of-range settings leave the current unreduced.
    end
  endfunction

  // True once the millisecond count has reached the delay.
  function automatic logic elapsed(input logic [31:0] count, input logic [31:0] delay);
    elapsed = (count >= delay);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond time base.

  logic msTick;

  ms_tick_divider #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .msTick(msTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [31:0] closeIdle_q, closeIdle_d;
  logic [31:0] shutdownIdle_q, shutdownIdle_d;
  logic [31:0] openDelay_q, openDelay_d;
  logic [31:0] startDelay_q, startDelay_d;
  logic [31:0] pwmFreq_q, pwmFreq_d;
  logic [31:0] pwmDuty_q, pwmDuty_d;
  logic [31:0] idleTime_q, idleTime_d;
  logic signed [31:0] reduction_q, reduction_d;
  logic [31:0] readData_q, readData_d;
  logic ack_q, ack_d;
  logic error_q, error_d;

  // Decode one access per cycle; a write with an unaccepted value is refused
  // and leaves the stored value alone, so the brake never sees a bad setting.
  always_comb begin
    closeIdle_d = closeIdle_q;
    shutdownIdle_d = shutdownIdle_q;
    openDelay_d = openDelay_q;
    startDelay_d = startDelay_q;
    pwmFreq_d = pwmFreq_q;
    pwmDuty_d = pwmDuty_q;
    idleTime_d = idleTime_q;
    reduction_d = reduction_q;
    readData_d = readData_q;
    ack_d = odWrite || odRead;
    error_d = 1'b0;
    if (odIndex == brake_pkg::IDX_IDLE_TIME && odSubindex == brake_pkg::SUB_COUNT) begin
      readData_d = idleTime_q;
      if (odWrite) idleTime_d = odWriteData;
    end else if (odIndex == brake_pkg::IDX_REDUCTION && odSubindex == brake_pkg::SUB_COUNT) begin
      readData_d = reduction_q;
      if (odWrite) reduction_d = odWriteData;
    end else if (odIndex == brake_pkg::IDX_BRAKE_TIMING) begin
      if (odSubindex == brake_pkg::SUB_COUNT) begin
        readData_d = {24'h0, brake_pkg::BRAKE_ENTRY_COUNT};
        error_d = odWrite;
      end else if (odSubindex == brake_pkg::SUB_1) begin
        readData_d = closeIdle_q;
        if (odWrite) closeIdle_d = odWriteData;
      end else if (odSubindex == brake_pkg::SUB_2) begin
        readData_d = shutdownIdle_q;
        if (odWrite) shutdownIdle_d = odWriteData;
      end else if (odSubindex == brake_pkg::SUB_3) begin
        readData_d = openDelay_q;
        if (odWrite) openDelay_d = odWriteData;
      end else if (odSubindex == brake_pkg::SUB_4) begin
        readData_d = startDelay_q;
        if (odWrite) startDelay_d = odWriteData;
      end else if (odSubindex == brake_pkg::SUB_5) begin
        readData_d = pwmFreq_q;
        if (odWrite) begin
          if (odWriteData <= brake_pkg::FREQ_PLAIN_MAX ||
              (odWriteData >= brake_pkg::FREQ_PWM_MIN &&
               odWriteData <= brake_pkg::FREQ_PWM_MAX)) begin
            pwmFreq_d = odWriteData;
          end else begin
            error_d = 1'b1;
          end
        end
      end else if (odSubindex == brake_pkg::SUB_6) begin
        readData_d = pwmDuty_q;
        if (odWrite) begin
          if (odWriteData == '0 || (odWriteData >= brake_pkg::DUTY_MIN &&
                                    odWriteData <= brake_pkg::DUTY_MAX)) begin
            pwmDuty_d = odWriteData;
          end else begin
            error_d = 1'b1;
          end
        end
      end else begin
        readData_d = '0;
        error_d = ack_d;
      end
    end else if (odIndex == brake_pkg::IDX_CURRENTS) begin
      // The whole readout group is read only.
      error_d = odWrite;
      if (odSubindex == brake_pkg::SUB_COUNT) begin
        readData_d = {24'h0, brake_pkg::CURRENT_ENTRY_COUNT};
      end else if (odSubindex == brake_pkg::SUB_1) begin
        readData_d = closedLoopActive ? measDirect : '0;
      end else if (odSubindex == brake_pkg::SUB_2) begin
        readData_d = closedLoopActive ? measQuadrature : '0;
      end else if (odSubindex == brake_pkg::SUB_3) begin
        readData_d = measAlpha;
      end else if (odSubindex == brake_pkg::SUB_4) begin
        readData_d = measBeta;
      end else if (odSubindex == brake_pkg::SUB_5) begin
        readData_d = measActual;
      end else begin
        readData_d = '0;
        error_d = ack_d;
      end
    end else begin
      readData_d = '0;
      error_d = ack_d;
    end
    if (!ack_d) begin
      readData_d = readData_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      closeIdle_q <= brake_pkg::DEFAULT_DELAY_MS;
      shutdownIdle_q <= brake_pkg::DEFAULT_DELAY_MS;
      openDelay_q <= brake_pkg::DEFAULT_DELAY_MS;
      startDelay_q <= brake_pkg::DEFAULT_START_MS;
      pwmFreq_q <= brake_pkg::DEFAULT_PWM_FREQ;
      pwmDuty_q <= brake_pkg::DEFAULT_PWM_DUTY;
      idleTime_q <= brake_pkg::DEFAULT_IDLE_MS;
      reduction_q <= brake_pkg::DEFAULT_REDUCTION;
      readData_q <= '0;
      ack_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      closeIdle_q <= closeIdle_d;
      shutdownIdle_q <= shutdownIdle_d;
      openDelay_q <= openDelay_d;
      startDelay_q <= startDelay_d;
      pwmFreq_q <= pwmFreq_d;
      pwmDuty_q <= pwmDuty_d;
      idleTime_q <= idleTime_d;
      reduction_q <= reduction_d;
      readData_q <= readData_d;
      ack_q <= ack_d;
      error_q <= error_d;
    end
  end

  assign odReadData = readData_q;
  assign odAck = ack_q;
  assign odError = error_q;

  //////////////////////////////////////////////////////////////////////////////
  // Brake sequence state machine.

  typedef enum logic [2:0] {
    ST_OFF,
    ST_OPEN_WAIT,
    ST_START_WAIT,
    ST_ENABLED,
    ST_CLOSE_WAIT,
    ST_SHUTDOWN_WAIT
  } seq_state_e;

  seq_state_e state_q, state_d;
  logic [31:0] seqMs_q, seqMs_d;

  // The ms counter restarts on every state change; a delay of zero passes in
  // one cycle. Because the tick is free running, a delay of N ms lasts
  // between N-1 and N ms, the usual trade-off of a shared time base.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (enableRequest) state_d = ST_OPEN_WAIT;
      end
      ST_OPEN_WAIT: begin
        if (!enableRequest) state_d = ST_OFF;
        else if (elapsed(seqMs_q, openDelay_q)) state_d = ST_START_WAIT;
      end
      ST_START_WAIT: begin
        if (!enableRequest) state_d = ST_CLOSE_WAIT;
        else if (elapsed(seqMs_q, startDelay_q)) state_d = ST_ENABLED;
      end
      ST_ENABLED: begin
        if (!enableRequest && motorStandstill) state_d = ST_CLOSE_WAIT;
      end
      ST_CLOSE_WAIT: begin
        if (enableRequest) state_d = ST_ENABLED;
        else if (elapsed(seqMs_q, closeIdle_q)) state_d = ST_SHUTDOWN_WAIT;
      end
      ST_SHUTDOWN_WAIT: begin
        if (elapsed(seqMs_q, shutdownIdle_q)) state_d = ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
    if (state_d != state_q) begin
      seqMs_d = '0;
    end else if (msTick && seqMs_q != '1) begin
      seqMs_d = seqMs_q + 32'h1;
    end else begin
      seqMs_d = seqMs_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      seqMs_q <= '0;
    end else begin
      state_q <= state_d;
      seqMs_q <= seqMs_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequence outputs and standstill reduction.

  logic [31:0] idleMs_q, idleMs_d;
  logic reduce_q, reduce_d;
  logic [31:0] setpoint_q, setpoint_d;
  logic currentOn_q, currentOn_d;
  logic brakeCmd_q, brakeCmd_d;
  logic opEnabled_q, opEnabled_d;

  // Current is on in every state but off; the brake is open only from the
  // end of the open delay until the close idle time has run out.
  always_comb begin
    currentOn_d = (state_d != ST_OFF);
    brakeCmd_d = (state_d == ST_START_WAIT || state_d == ST_ENABLED ||
                  state_d == ST_CLOSE_WAIT);
    opEnabled_d = (state_d == ST_ENABLED);
    if (!motorStandstill || !currentOn_q) begin
      idleMs_d = '0;
    end else if (msTick && idleMs_q != '1) begin
      idleMs_d = idleMs_q + 32'h1;
    end else begin
      idleMs_d = idleMs_q;
    end
    reduce_d = currentOn_q && motorStandstill && elapsed(idleMs_q, idleTime_q);
    if (reduce_q) begin
      setpoint_d = reducedCurrent(reduction_q, ratedCurrentMa);
    end else begin
      setpoint_d = ratedCurrentMa;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleMs_q <= '0;
      reduce_q <= 1'b0;
      setpoint_q <= '0;
      currentOn_q <= 1'b0;
      brakeCmd_q <= 1'b0;
      opEnabled_q <= 1'b0;
    end else begin
      idleMs_q <= idleMs_d;
      reduce_q <= reduce_d;
      setpoint_q <= setpoint_d;
      currentOn_q <= currentOn_d;
      brakeCmd_q <= brakeCmd_d;
      opEnabled_q <= opEnabled_d;
    end
  end

  assign motorCurrentOn = currentOn_q;
  assign brakeOpenCmd = brakeCmd_q;
  assign operationEnabled = opEnabled_q;
  assign reductionActive = reduce_q;
  assign currentSetpointMa = setpoint_q;

  //////////////////////////////////////////////////////////////////////////////
  // Brake driver.

  brake_pwm u_pwm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .brakeOpen(brakeCmd_q),
    .freqHz(pwmFreq_q),
    .dutyPct(pwmDuty_q),
    .brakeOut(brakeOut)
  );

endmodule // brake_sequencer

// ### hw/ms_tick_divider.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Divides the reference clock down to a one-cycle pulse every millisecond.
module ms_tick_divider #(
  parameter int CYCLES = brake_pkg::CYCLES_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic msTick
);

  logic [31:0] count_q;
  logic [31:0] count_d;

  // The pulse comes from the wrap so it is exactly one cycle wide.
  always_comb begin
    if (count_q == 32'(CYCLES - 1)) begin
      count_d = '0;
    end else begin
      count_d = count_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign msTick = (count_q == 32'(CYCLES - 1));

endmodule // ms_tick_divider

// ### inc/brake_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package brake_pkg;

  // Object dictionary indices.
  localparam logic [15:0] IDX_IDLE_TIME = 16'h2036;
  localparam logic [15:0] IDX_REDUCTION = 16'h2037;
  localparam logic [15:0] IDX_BRAKE_TIMING = 16'h2038;
  localparam logic [15:0] IDX_CURRENTS = 16'h2039;

  // Subindices shared by both groups; SUB_6 is used by the timing group only.
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_1 = 8'h01;
  localparam logic [7:0] SUB_2 = 8'h02;
  localparam logic [7:0] SUB_3 = 8'h03;
  localparam logic [7:0] SUB_4 = 8'h04;
  localparam logic [7:0] SUB_5 = 8'h05;
  localparam logic [7:0] SUB_6 = 8'h06;

  // Entry counts and reset values.
  localparam logic [7:0] BRAKE_ENTRY_COUNT = 8'h06;
  localparam logic [7:0] CURRENT_ENTRY_COUNT = 8'h05;
  localparam logic [31:0] DEFAULT_DELAY_MS = 32'h000003e8;
  localparam logic [31:0] DEFAULT_START_MS = 32'h00000000;
  localparam logic [31:0] DEFAULT_IDLE_MS = 32'h000003e8;
  localparam logic [31:0] DEFAULT_REDUCTION = 32'hffffffce;
  localparam logic [31:0] DEFAULT_PWM_FREQ = 32'h00000000;
  localparam logic [31:0] DEFAULT_PWM_DUTY = 32'h00000000;

  // Accepted ranges.
  localparam logic [31:0] FREQ_PLAIN_MAX = 32'h00000032;
  localparam logic [31:0] FREQ_PWM_MIN = 32'h000007d0;
  localparam logic [31:0] FREQ_PWM_MAX = 32'h00004e20;
  localparam logic [31:0] DUTY_MIN = 32'h00000002;
  localparam logic [31:0] DUTY_MAX = 32'h00000064;
  localparam logic signed [31:0] PERCENT_MIN = -32'sd100;
  localparam logic signed [31:0] PERCENT_FULL = 32'sd100;

  // Timing.
  localparam int CLOCK_HZ = 125000000;
  localparam int MS_PER_TICK = 1;
  localparam int MS_PER_SECOND = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_SECOND * MS_PER_TICK;
  localparam logic [31:0] CLOCK_HZ_W = 32'd125000000;
  localparam logic [31:0] CYCLES_PER_PERCENT = 32'd1250000;

endpackage : brake_pkg

// ### verification/brake_sequencer_asserts.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Port-level checks on the object access port and the brake order.
module brake_sequencer_asserts #(
  parameter int CYCLES_PER_MS = 125000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic odWrite,
  input wire logic odRead,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubindex,
  input wire logic [31:0] odReadData,
  input wire logic odAck,
  input wire logic odError,
  input wire logic closedLoopActive,
  input wire logic motorCurrentOn,
  input wire logic brakeOpenCmd,
  input wire logic brakeOut,
  input wire logic operationEnabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Steps of an access, named so the properties read as the handshake.
  sequence accessReq;
    odWrite || odRead;
  endsequence
  sequence openLoopDqRead;
    odRead && odIndex == 16'h2039 && odSubindex inside {8'h01, 8'h02} && !closedLoopActive;
  endsequence

  ack_follows_req_a: assert property (accessReq |=> odAck)
    else $error("no acknowledge one cycle after a request");
  ack_needs_req_a: assert property (!(odWrite || odRead) |=> !odAck)
    else $error("acknowledge without a request");
  error_with_ack_a: assert property (odError |-> odAck)
    else $error("error flag outside an acknowledge");
  readout_ro_a: assert property (odWrite && odIndex == 16'h2039 |=> odError)
    else $error("write to current readout accepted");
  count_ro_a: assert property (odWrite && odIndex == 16'h2038 && odSubindex == 8'h00 |=> odError)
    else $error("write to entry count accepted");
  dq_zero_a: assert property (openLoopDqRead |=> odReadData == 32'h0)
    else $error("axis current shown outside closed loop");
  brake_needs_current_a: assert property (brakeOpenCmd |-> motorCurrentOn)
    else $error("brake open without motor current");
  op_needs_brake_a: assert property (operationEnabled |-> brakeOpenCmd)
    else $error("operation enabled with brake closed");
  pin_closed_a: assert property (!brakeOpenCmd |=> !brakeOut)
    else $error("brake pin active while brake commanded closed");
  current_first_a: assert property ($rose(motorCurrentOn) |-> !brakeOpenCmd)
    else $error("brake opened together with current");
endmodule // brake_sequencer_asserts

bind brake_sequencer brake_sequencer_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (
  .ref_clk, .rst_n, .odWrite, .odRead, .odIndex, .odSubindex, .odReadData, .odAck,
  .odError, .closedLoopActive, .motorCurrentOn, .brakeOpenCmd, .brakeOut, .operationEnabled);

// ### verification/plant_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Power stage and brake coil stand-in; the sensed currents are fixed so that
// readouts can be predicted, a limitation against a moving motor.
module plant_model #(
  parameter logic [31:0] CUR_D = 32'h0,
  parameter logic [31:0] CUR_Q = 32'h0,
  parameter logic [31:0] CUR_A = 32'h0,
  parameter logic [31:0] CUR_B = 32'h0,
  parameter logic [31:0] CUR_X = 32'h0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic brakeOut,
  output logic signed [31:0] measDirect,
  output logic signed [31:0] measQuadrature,
  output logic signed [31:0] measAlpha,
  output logic signed [31:0] measBeta,
  output logic signed [31:0] measActual,
  output logic coilOn_q
);
  logic coilOn_d;

  // Sensed peak currents.
  assign measDirect = CUR_D;
  assign measQuadrature = CUR_Q;
  assign measAlpha = CUR_A;
  assign measBeta = CUR_B;
  assign measActual = CUR_X;

  // The coil follows the pin one cycle late, like a slow driver.
  always_comb begin
    coilOn_d = brakeOut;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) coilOn_q <= 1'b0;
    else coilOn_q <= coilOn_d;
  end
endmodule // plant_model

// ### verification/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////
module testbench;
  localparam int MS = 10;
  localparam logic [31:0] CD = 32'h000004b0;
  localparam logic [31:0] CQ = 32'hfffffce0;
  localparam logic [31:0] CA = 32'h00000321;
  localparam logic [31:0] CB = 32'hfffffa00;
  localparam logic [31:0] CX = 32'h00000777;
  logic ref_clk, rst_n, odWrite, odRead, odAck, odError, er, ak;
  logic enableRequest, motorStandstill, closedLoopActive;
  logic motorCurrentOn, brakeOpenCmd, brakeOut, operationEnabled, reductionActive;
  logic [15:0] odIndex;
  logic [7:0] odSubindex;
  logic [31:0] odWriteData, odReadData, ratedCurrentMa, currentSetpointMa, rd;
  logic signed [31:0] measDirect, measQuadrature, measAlpha, measBeta, measActual;
  int miscompares, nTests, cyc, n;

  brake_sequencer #(.CYCLES_PER_MS(MS)) dut (.ref_clk, .rst_n, .odWrite, .odRead, .odIndex,
    .odSubindex, .odWriteData, .odReadData, .odAck, .odError, .enableRequest,
    .motorStandstill, .closedLoopActive, .ratedCurrentMa, .measDirect, .measQuadrature,
    .measAlpha, .measBeta, .measActual, .motorCurrentOn, .brakeOpenCmd, .brakeOut,
    .operationEnabled, .reductionActive, .currentSetpointMa);

  plant_model #(.CUR_D(CD), .CUR_Q(CQ), .CUR_A(CA), .CUR_B(CB), .CUR_X(CX)) plant (
    .ref_clk, .rst_n, .brakeOut, .measDirect, .measQuadrature, .measAlpha, .measBeta,
    .measActual, .coilOn_q());

  // Free-running clock, 8 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////
  task end_sim;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One access; the strobe stands for one sampling edge and the answer is taken just after it.
  task acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    @(posedge ref_clk);
    odWrite <= w;
    odRead <= !w;
    odIndex <= idx;
    odSubindex <= sub;
    odWriteData <= d;
    @(posedge ref_clk);
    odWrite <= 1'b0;
    odRead <= 1'b0;
    #1;
    ak = odAck;
    rd = odReadData;
    er = odError;
    @(posedge ref_clk);
    #1;
    chk(ak, 32'h1, "ack");
    chk(odAck, 32'h0, "ack width");
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
    acc(1'b1, idx, sub, d);
    chk(er, e, "write error");
  endtask

  task rdv(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    acc(1'b0, idx, sub, 32'h0);
    chk(er, 32'h0, "read error");
    chk(rd, exp, "read value");
  endtask

  function automatic logic sg(input int k);
    case (k)
      0: return motorCurrentOn;
      1: return brakeOpenCmd;
      2: return operationEnabled;
      3: return reductionActive;
      default: return brakeOut;
    endcase
  endfunction

  // Bounded wait for a level; n returns the cycles spent.
  task waitLvl(input int k, input logic v);
    n = 0;
    while (sg(k) !== v && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////
  task t_defaults;
    rdv(16'h2038, 8'h00, 32'h6);
    for (int s = 1; s <= 3; s++) rdv(16'h2038, s[7:0], 32'h3e8);
    rdv(16'h2038, 8'h04, 32'h0);
    rdv(16'h2038, 8'h05, 32'h0);
    rdv(16'h2038, 8'h06, 32'h0);
    rdv(16'h2039, 8'h00, 32'h5);
    rdv(16'h2036, 8'h00, 32'h3e8);
  endtask

  // Read-only and unknown places refuse writes; the entry count is read back and keeps its value.
  task t_refused;
    wr(16'h2038, 8'h00, 32'h7, 1'b1);
    rdv(16'h2038, 8'h00, 32'h6);
    for (int s = 1; s <= 5; s++) wr(16'h2039, s[7:0], 32'h1, 1'b1);
    wr(16'h203f, 8'h00, 32'h1, 1'b1);
  endtask

  // Range boundaries; a refused value leaves the last accepted one.
  task t_ranges;
    logic [31:0] fv[7] = '{32'h0, 32'h32, 32'h33, 32'h7cf, 32'h7d0, 32'h4e20, 32'h4e21};
    logic fe[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] dv[5] = '{32'h0, 32'h1, 32'h2, 32'h64, 32'h65};
    logic de[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] last;
    last = 32'h0;
    for (int i = 0; i < 7; i++) begin
      wr(16'h2038, 8'h05, fv[i], fe[i]);
      if (!fe[i]) last = fv[i];
      rdv(16'h2038, 8'h05, last);
    end
    for (int i = 0; i < 5; i++) begin
      wr(16'h2038, 8'h06, dv[i], de[i]);
      if (!de[i]) last = dv[i];
      rdv(16'h2038, 8'h06, last);
    end
  endtask

  task t_readout;
    @(posedge ref_clk);
    closedLoopActive <= 1'b0;
    rdv(16'h2039, 8'h01, 32'h0);
    rdv(16'h2039, 8'h02, 32'h0);
    rdv(16'h2039, 8'h03, CA);
    rdv(16'h2039, 8'h04, CB);
    rdv(16'h2039, 8'h05, CX);
    @(posedge ref_clk);
    closedLoopActive <= 1'b1;
    rdv(16'h2039, 8'h01, CD);
    rdv(16'h2039, 8'h02, CQ);
  endtask

  // Enable and shut down with delays of 2, 1, 2 and 2 ms.
  task t_sequence;
    wr(16'h2038, 8'h03, 32'h2, 1'b0);
    wr(16'h2038, 8'h04, 32'h1, 1'b0);
    wr(16'h2038, 8'h01, 32'h2, 1'b0);
    wr(16'h2038, 8'h02, 32'h2, 1'b0);
    wr(16'h2038, 8'h05, 32'h0, 1'b0);
    wr(16'h2038, 8'h06, 32'h0, 1'b0);
    @(posedge ref_clk);
    enableRequest <= 1'b1;
    waitLvl(0, 1'b1);
    chk(brakeOpenCmd, 32'h0, "brake before current");
    waitLvl(1, 1'b1);
    chk(n >= MS + 1 && n <= 2 * MS + 1, 32'h1, "open delay");
    waitLvl(2, 1'b1);
    chk(n >= 1 && n <= MS + 1, 32'h1, "start delay");
    chk(brakeOut, 32'h1, "static pin");
    @(posedge ref_clk);
    enableRequest <= 1'b0;
    motorStandstill <= 1'b1;
    waitLvl(1, 1'b0);
    chk(n >= MS + 1 && n <= 2 * MS + 3, 32'h1, "close idle");
    chk(motorCurrentOn, 32'h1, "current during close");
    waitLvl(0, 1'b0);
    chk(n >= MS + 1 && n <= 2 * MS + 1, 32'h1, "shutdown idle");
    chk(brakeOut, 32'h0, "pin released");
  endtask

  // Standstill reduction at 4200 mA rated, 1 ms idle time.
  task t_reduction;
    wr(16'h2036, 8'h00, 32'h1, 1'b0);
    wr(16'h2037, 8'h00, 32'hffffffc4, 1'b0);
    @(posedge ref_clk);
    enableRequest <= 1'b1;
    waitLvl(0, 1'b1);
    chk(reductionActive, 32'h0, "reduction before idle");
    waitLvl(3, 1'b1);
    chk(n >= 1 && n <= MS, 32'h1, "idle time");
    waitLvl(2, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(currentSetpointMa, 32'h690, "percent setpoint");
    wr(16'h2037, 8'h00, 32'hffffff9c, 1'b0);
    chk(currentSetpointMa, 32'h0, "zero setpoint");
    wr(16'h2037, 8'h00, 32'h1f4, 1'b0);
    chk(currentSetpointMa, 32'h1f4, "absolute setpoint");
  endtask

  // 2 kHz at 50 percent: one period is 62500 cycles, half of them high.
  task t_pwm;
    int hi;
    wr(16'h2038, 8'h05, 32'h7d0, 1'b0);
    wr(16'h2038, 8'h06, 32'h32, 1'b0);
    hi = 0;
    repeat (62500) begin
      @(posedge ref_clk);
      #1;
      if (brakeOut === 1'b1) hi++;
    end
    chk(hi >= 31249 && hi <= 31251, 32'h1, "pwm high time");
  endtask

  ////////////////////////////////////////
  // Cuts a hang short well above the expected run length.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    {rst_n, odWrite, odRead, enableRequest, motorStandstill, closedLoopActive} = 6'h0;
    odIndex = 16'h0;
    odSubindex = 8'h0;
    odWriteData = 32'h0;
    ratedCurrentMa = 32'h1068;
    miscompares = 0;
    nTests = 0;
    cyc = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_defaults();
    t_refused();
    t_ranges();
    t_readout();
    t_sequence();
    t_reduction();
    t_pwm();
    end_sim();
  end
endmodule // testbench
